/* core/xpp_cfg.svh */
`ifndef XPP_CFG_SVH
`define XPP_CFG_SVH
`define XPP_NUM_OUTPUTS 5
`define XPP_ENTRY_W 5
`define XPP_SEL_W 4
`define XPP_ADDR_W 3
`define XPP_EN_BIT 4
`define XPP_SER_BITS 45
`define XPP_PAD_BITS 5
`define XPP_SLOT_BITS 10
`define XPP_SER_CNT_W 6
`define XPP_ENTRY_OFF 5'h00
`endif

/* core/xpp_pkg.sv */
`include "xpp_cfg.svh"
package xpp_pkg;
    typedef logic [`XPP_ENTRY_W-1:0] xpp_entry_t;
    typedef logic [`XPP_NUM_OUTPUTS*`XPP_ENTRY_W-1:0] xpp_matrix_t;
    typedef logic [`XPP_ADDR_W-1:0] xpp_addr_t;
endpackage

/* core/xpp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module xpp_sync
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;
    // ---------------------------------------------------------------
    // two-stage synchroniser; reset value is the inactive high level
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            meta_reg <= 1'h1;
            q_out <= 1'h1;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* core/xpp_port.sv */
// Contract
// - one write and commit reprograms chosen outputs, others untouched
// - matrix reset low disables all outputs, keeps staged and routing data
// - programming registers have no defined value after power-up
// - three-bit address picks which output entry a write targets
// - four select bits name which of sixteen inputs feeds the output
// - fifth bit enables output; low means disabled, select ignored
// - write strobe falling edge captures address and data into staging
// - staged entries reach routing only while commit is low
// - several writes stage entries; one commit applies them together
// - serial load rewrites the whole matrix every time
// - commit latches are transparent whenever commit and chip select are both low
// - chip select high holds shift clock and commit inactive high
// - serial data sampled on shift clock falling edge, 45 bits per load
`timescale 1ns/1ps
`default_nettype none
`include "xpp_cfg.svh"
module xpp_port
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic chip_select_n_in,
    input wire logic serial_parallel_select_in,
    input wire logic write_strobe_n_in,
    input wire logic shift_clock_n_in,
    input wire logic commit_n_in,
    input wire logic matrix_reset_n_in,
    input wire logic init_clear_in,
    input wire logic serial_data_in,
    input wire xpp_pkg::xpp_addr_t output_addr_in,
    input wire logic [`XPP_ENTRY_W-1:0] data_in,
    output logic [`XPP_NUM_OUTPUTS-1:0] output_enable_out,
    output xpp_pkg::xpp_matrix_t route_out,
    output logic serial_data_out
);
    import xpp_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic cs_n_s, mode_s, we_n_s, sclk_n_s, upd_n_s, rst_n_s, clr_s, sin_s;
    xpp_sync u_cs (.clk_in(clk_in), .reset_in(reset_in), .d_in(chip_select_n_in), .q_out(cs_n_s));
    xpp_sync u_md (.clk_in(clk_in), .reset_in(reset_in),
        .d_in(serial_parallel_select_in), .q_out(mode_s));
    xpp_sync u_we (.clk_in(clk_in), .reset_in(reset_in), .d_in(write_strobe_n_in), .q_out(we_n_s));
    xpp_sync u_sc (.clk_in(clk_in), .reset_in(reset_in), .d_in(shift_clock_n_in), .q_out(sclk_n_s));
    xpp_sync u_up (.clk_in(clk_in), .reset_in(reset_in), .d_in(commit_n_in), .q_out(upd_n_s));
    xpp_sync u_rs (.clk_in(clk_in), .reset_in(reset_in), .d_in(matrix_reset_n_in), .q_out(rst_n_s));
    xpp_sync u_cl (.clk_in(clk_in), .reset_in(reset_in), .d_in(init_clear_in), .q_out(clr_s));
    xpp_sync u_si (.clk_in(clk_in), .reset_in(reset_in), .d_in(serial_data_in), .q_out(sin_s));

    // address and data held stable by host around the strobe edge
    xpp_addr_t addr_s1, addr_s2;
    xpp_entry_t data_s1, data_s2;
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            addr_s1 <= '0;
            addr_s2 <= '0;
            data_s1 <= '0;
            data_s2 <= '0;
        end
        else
        begin
            addr_s1 <= output_addr_in;
            addr_s2 <= addr_s1;
            data_s1 <= data_in;
            data_s2 <= data_s1;
        end
    end

    // ---------------------------------------------------------------
    // gated strobes
    // ---------------------------------------------------------------
    logic sclk_gated, upd_gated, we_prev_reg, sclk_prev_reg;
    logic we_fall, sclk_fall;
    assign sclk_gated = cs_n_s | sclk_n_s;
    assign upd_gated = cs_n_s | upd_n_s;
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            we_prev_reg <= 1'h1;
            sclk_prev_reg <= 1'h1;
        end
        else
        begin
            we_prev_reg <= we_n_s;
            sclk_prev_reg <= sclk_gated;
        end
    end
    assign we_fall = we_prev_reg & ~we_n_s & ~cs_n_s & mode_s;
    assign sclk_fall = sclk_prev_reg & ~sclk_gated & ~mode_s;

    // ---------------------------------------------------------------
    // staging register (45-bit chain holds entries and padding)
    // ---------------------------------------------------------------
    // no reset: contents are undefined after power-up, and matrix reset
    // must not disturb them
    logic [`XPP_SER_BITS-1:0] stage_reg;
    logic addr_ok;
    xpp_entry_t wr_entry;
    assign addr_ok = (addr_s2 < `XPP_ADDR_W'(`XPP_NUM_OUTPUTS));
    // clear forces the off-state entry during the first init pass
    assign wr_entry = clr_s ? `XPP_ENTRY_OFF : data_s2;
    always_ff @(posedge clk_in)
    begin
        // serial path wins if both strobes land in one cycle
        if (sclk_fall)
            stage_reg <= {stage_reg[`XPP_SER_BITS-2:0], sin_s};
        else if (we_fall && addr_ok)
        begin
            // output k sits at slot k*10; msb output shifted in first
            for (int k = 0; k < `XPP_NUM_OUTPUTS; k++)
            begin
                if (addr_s2 == `XPP_ADDR_W'(k))
                    stage_reg[k*`XPP_SLOT_BITS +: `XPP_ENTRY_W] <= wr_entry;
            end
        end
    end

    // ---------------------------------------------------------------
    // commit latches and output stage
    // ---------------------------------------------------------------
    // transparent latch is modelled as a per-clock copy while commit low
    // limitation: commit pulses under one clock may be missed
    xpp_matrix_t matrix_reg;
    always_ff @(posedge clk_in)
    begin
        if (!upd_gated)
        begin
            for (int k = 0; k < `XPP_NUM_OUTPUTS; k++)
                matrix_reg[k*`XPP_ENTRY_W +: `XPP_ENTRY_W] <=
                    stage_reg[k*`XPP_SLOT_BITS +: `XPP_ENTRY_W];
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            output_enable_out <= '0;
            route_out <= '0;
            serial_data_out <= 1'h0;
        end
        else
        begin
            for (int k = 0; k < `XPP_NUM_OUTPUTS; k++)
                output_enable_out[k] <= rst_n_s &
                    matrix_reg[k*`XPP_ENTRY_W + `XPP_EN_BIT];
            route_out <= matrix_reg;
            serial_data_out <= stage_reg[`XPP_SER_BITS-1];
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // staging and matrix start unknown, so hold checks use $stable
    matrix_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        upd_gated |=> $stable(matrix_reg))
        else $error("matrix changed while commit high");
    reset_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !rst_n_s |=> output_enable_out == '0)
        else $error("output enabled during matrix reset");
    reset_keep_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (!rst_n_s && !we_fall && !sclk_fall) |=> $stable(stage_reg))
        else $error("matrix reset disturbed staging");
    bad_addr_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (we_fall && !addr_ok && !sclk_fall) |=> $stable(stage_reg))
        else $error("staging changed on bad address");
    strobe_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
        cs_n_s |=> ($stable(stage_reg) && $stable(matrix_reg)))
        else $error("strobes not gated by chip select");
    mode_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (!mode_s && !sclk_fall) |=> $stable(stage_reg))
        else $error("parallel write taken in serial mode");
    shift_in_a: assert property (@(posedge clk_in) disable iff (reset_in)
        sclk_fall |=> stage_reg[0] == $past(sin_s))
        else $error("serial bit not captured");
    write_cap_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (we_fall && addr_ok && !clr_s && addr_s2 == 3'h0) |=>
        stage_reg[`XPP_ENTRY_W-1:0] == $past(data_s2))
        else $error("write not captured");
    commit_pass_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !upd_gated |=> matrix_reg[`XPP_ENTRY_W-1:0] ==
        $past(stage_reg[`XPP_ENTRY_W-1:0]))
        else $error("commit latch not transparent");
    route_copy_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !upd_gated |=> ##1 (route_out == $past(matrix_reg)))
        else $error("route does not follow matrix");

    // per-output checks
    for (genvar k = 0; k < `XPP_NUM_OUTPUTS; k++)
    begin : g_slot_chk
        slot_keep_a: assert property (@(posedge clk_in) disable iff (reset_in)
            (we_fall && addr_s2 != `XPP_ADDR_W'(k)) |=>
            $stable(stage_reg[k*`XPP_SLOT_BITS +: `XPP_ENTRY_W]))
            else $error("write disturbed another staged entry");
        slot_cap_a: assert property (@(posedge clk_in) disable iff (reset_in)
            (we_fall && !clr_s && addr_s2 == `XPP_ADDR_W'(k)) |=>
            stage_reg[k*`XPP_SLOT_BITS +: `XPP_ENTRY_W] == $past(data_s2))
            else $error("write not captured in addressed entry");
        slot_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
            (we_fall && clr_s && addr_s2 == `XPP_ADDR_W'(k)) |=>
            stage_reg[k*`XPP_SLOT_BITS +: `XPP_ENTRY_W] == `XPP_ENTRY_OFF)
            else $error("clear did not store the off entry");
        enable_map_a: assert property (@(posedge clk_in) disable iff (reset_in)
            !upd_gated |=> ##1 (output_enable_out[k] ==
            ($past(rst_n_s) && $past(matrix_reg[k*`XPP_ENTRY_W + `XPP_EN_BIT]))))
            else $error("output enable does not follow matrix");
    end
endmodule
`default_nettype wire

/* test/xpp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module xpp_host
(
    input wire logic clk_in,
    output logic cs_n_out,
    output logic mode_out,
    output logic we_n_out,
    output logic sclk_n_out,
    output logic commit_n_out,
    output logic mrst_n_out,
    output logic clear_out,
    output logic sdata_out,
    output xpp_pkg::xpp_addr_t addr_out,
    output logic [4:0] data_out
);
    import xpp_pkg::*;
    initial
    begin
        cs_n_out = 1'h0;
        mode_out = 1'h1;
        we_n_out = 1'h1;
        sclk_n_out = 1'h1;
        commit_n_out = 1'h1;
        mrst_n_out = 1'h1;
        clear_out = 1'h0;
        sdata_out = 1'h0;
        addr_out = 3'h0;
        data_out = 5'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // levels held 4 cycles, syncs need 2
    task automatic wr(input logic [2:0] a, input logic [4:0] d);
        addr_out <= a;
        data_out <= d;
        tick(4);
        we_n_out <= 1'h0;
        tick(4);
        we_n_out <= 1'h1;
        tick(4);
        // stale values are not kept after hold
        addr_out <= ~a;
        data_out <= ~d;
        tick(1);
    endtask
    task automatic commit();
        commit_n_out <= 1'h0;
        tick(8);
        commit_n_out <= 1'h1;
        tick(4);
    endtask
    task automatic shift(input logic [44:0] w);
        mode_out <= 1'h0;
        for (int i = 44; i >= 0; i--)
        begin
            sdata_out <= w[i];
            tick(4);
            sclk_n_out <= 1'h0;
            tick(4);
            sclk_n_out <= 1'h1;
        end
        sdata_out <= ~w[0];
        mode_out <= 1'h1;
        tick(4);
    endtask
endmodule
`default_nettype wire

/* test/xpp_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module xpp_port_tb;
    import xpp_pkg::*;
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic cs_n, mode, we_n, sclk_n, cm_n, mrst_n, clr, sd, sdo;
    xpp_addr_t addr;
    logic [4:0] data, en;
    xpp_matrix_t route, exp_r;
    int err_total = 0;
    int checks_done = 0;
    // {addr, data, enables after}: one write then one commit per row
    logic [12:0] rows [8] = '{13'h0261, 13'h0541, 13'h0BE5, 13'h0E0D, 13'h12BD, 13'h17FD,
        13'h1FFD, 13'h10ED};
    always #12.5 clk_in = ~clk_in;
    xpp_host u_host (.clk_in(clk_in), .cs_n_out(cs_n), .mode_out(mode), .we_n_out(we_n),
        .sclk_n_out(sclk_n), .commit_n_out(cm_n), .mrst_n_out(mrst_n), .clear_out(clr),
        .sdata_out(sd), .addr_out(addr), .data_out(data));
    xpp_port u_dut (.clk_in(clk_in), .reset_in(reset_in), .chip_select_n_in(cs_n),
        .serial_parallel_select_in(mode), .write_strobe_n_in(we_n), .shift_clock_n_in(sclk_n),
        .commit_n_in(cm_n), .matrix_reset_n_in(mrst_n), .init_clear_in(clr),
        .serial_data_in(sd), .output_addr_in(addr), .data_in(data),
        .output_enable_out(en), .route_out(route), .serial_data_out(sdo));
    function automatic logic [4:0] en_of(xpp_matrix_t r);
        for (int k = 0; k < 5; k++)
            en_of[k] = r[5*k+4];
    endfunction
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic look();
        `CHK("route", exp_r, route)
        `CHK("enable", en_of(exp_r), en)
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'h0;
        u_host.tick(2);
        u_host.clear_out <= 1'h1;
        for (int k = 4; k >= 0; k--)
            u_host.wr(k[2:0], 5'h1F);
        u_host.commit();
        u_host.clear_out <= 1'h0;
        exp_r = '0;
        look();
        foreach (rows[i])
        begin
            u_host.wr(rows[i][12:10], rows[i][9:5]);
            u_host.commit();
            if (rows[i][12:10] < 3'h5)
                exp_r[5*rows[i][12:10] +: 5] = rows[i][9:5];
            look();
            `CHK("row_enable", rows[i][4:0], en)
        end
        u_host.wr(3'h0, 5'h11);
        u_host.wr(3'h3, 5'h1E);
        `CHK("staged", exp_r, route)
        u_host.commit();
        exp_r[4:0] = 5'h11;
        exp_r[19:15] = 5'h1E;
        look();
        u_host.mrst_n_out <= 1'h0;
        u_host.tick(8);
        `CHK("mreset", 5'h00, en)
        u_host.mrst_n_out <= 1'h1;
        u_host.tick(8);
        look();
        u_host.cs_n_out <= 1'h1;
        u_host.wr(3'h1, 5'h19);
        u_host.commit();
        look();
        u_host.cs_n_out <= 1'h0;
        u_host.commit();
        look();
        `CHK("serout", 1'h0, sdo)
        u_host.shift({5'h12, 5'h00, 5'h1C, 5'h00, 5'h08, 5'h00, 5'h17, 5'h00, 5'h1B});
        `CHK("preserial", exp_r, route)
        u_host.commit();
        exp_r = {5'h12, 5'h1C, 5'h08, 5'h17, 5'h1B};
        look();
        `CHK("serout", 1'h1, sdo)
        tally_and_finish();
    end
endmodule
`default_nettype wire
